// ---- logic/mps_pkg.sv ----
// Constants shared by the PHY source selection block.
package mps_pkg;

    // Register port widths.
    localparam int MPS_ADDR_W = 8;
    localparam int MPS_DATA_W = 32;

    // Byte offset of the hardware configuration register.
    localparam logic [7:0] MPS_CONFIG_OFFSET = 8'h74;

    // Field positions inside the hardware configuration register.
    localparam int MPS_CLK_SEL_MSB = 6;
    localparam int MPS_CLK_SEL_LSB = 5;
    localparam int MPS_MGMT_SEL_BIT = 4;
    localparam int MPS_PRESENT_BIT = 3;
    localparam int MPS_PORT_EN_BIT = 2;
    localparam int MPS_USED_MSB = 6;

    // Reset values of the register fields, including the strap-loaded presence bit.
    localparam logic [1:0] MPS_CLK_SEL_RST = 2'h0;
    localparam logic MPS_MGMT_SEL_RST = 1'h0;
    localparam logic MPS_PORT_EN_RST = 1'h0;
    localparam logic MPS_PRESENT_RST = 1'h0;

    // Clock source encodings.
    localparam logic [1:0] MPS_CLK_INT_A = 2'h0;
    localparam logic [1:0] MPS_CLK_EXT = 2'h1;
    localparam logic [1:0] MPS_CLK_OFF = 2'h2;
    localparam logic [1:0] MPS_CLK_INT_B = 2'h3;

    // MII bundle widths: receive is {rxd, rx_dv, rx_er, crs, col}, transmit is {txd, tx_en, tx_er}.
    localparam int MPS_NIB_W = 4;
    localparam int MPS_RX_W = 8;
    localparam int MPS_TX_W = 6;

    // Strap capture sequence.
    typedef enum logic {
        MPS_STRAP_WAIT,
        MPS_STRAP_HELD
    } mps_strap_type;

endpackage

// ---- logic/mps_route_if.sv ----
// Selection fields passed from the register file to the routing logic.
`timescale 1ns/1ps
interface mps_route_if;
    logic [1:0] mii_clock_source_select;
    logic management_port_target_select;
    logic outboard_mii_port_enable;

    modport ctrl (
        output mii_clock_source_select,
        output management_port_target_select,
        output outboard_mii_port_enable
    );
    modport route (
        input mii_clock_source_select,
        input management_port_target_select,
        input outboard_mii_port_enable
    );
endinterface

// ---- logic/mps_route.sv ----
// Combinational routing of MII data, clocks and management lines.
`timescale 1ns/1ps
module mps_route (
    // Selection fields.
    mps_route_if.route cfg,
    // MAC side.
    input wire logic [mps_pkg::MPS_TX_W-1:0] mac_tx,
    input wire logic mac_mdc,
    input wire logic mac_mdio_o,
    input wire logic mac_mdio_oe,
    output logic [mps_pkg::MPS_RX_W-1:0] mac_rx_nxt,
    output logic mac_rx_clk_nxt,
    output logic mac_tx_clk_nxt,
    output logic mac_mdio_i_nxt,
    // Internal PHY side.
    input wire logic [mps_pkg::MPS_RX_W-1:0] int_rx,
    input wire logic int_rx_clk,
    input wire logic int_tx_clk,
    input wire logic int_mdio_i,
    output logic [mps_pkg::MPS_TX_W-1:0] int_tx_nxt,
    output logic int_mdc_nxt,
    output logic int_mdio_o_nxt,
    output logic int_mdio_oe_nxt,
    // External MII port side.
    input wire logic [mps_pkg::MPS_RX_W-1:0] ext_rx,
    input wire logic ext_rx_clk,
    input wire logic ext_tx_clk,
    input wire logic ext_mdio_i,
    output logic [mps_pkg::MPS_TX_W-1:0] ext_tx_nxt,
    output logic ext_mdc_nxt,
    output logic ext_mdio_o_nxt,
    output logic ext_mdio_oe_nxt
);
    import mps_pkg::*;

    wire logic port_ext;
    wire logic mgmt_ext;
    wire logic clk_from_int;
    wire logic clk_from_ext;

    // external port enable steers only the data bundles.
    assign port_ext = cfg.outboard_mii_port_enable;
    // disabled port sees zeros while the internal PHY is connected.
    assign mac_rx_nxt = port_ext ? ext_rx : int_rx;
    assign int_tx_nxt = port_ext ? '0 : mac_tx;
    assign ext_tx_nxt = port_ext ? mac_tx : '0;

    // two codes pick the internal PHY, one the port, one stops clocks.
    assign clk_from_int = (cfg.mii_clock_source_select == MPS_CLK_INT_A) ||
                          (cfg.mii_clock_source_select == MPS_CLK_INT_B);
    assign clk_from_ext = (cfg.mii_clock_source_select == MPS_CLK_EXT);
    // clock source field routes only receive and transmit clocks.
    assign mac_rx_clk_nxt = clk_from_int ? int_rx_clk : (clk_from_ext & ext_rx_clk);
    assign mac_tx_clk_nxt = clk_from_int ? int_tx_clk : (clk_from_ext & ext_tx_clk);

    // management target stands alone and moves only MDC and MDIO.
    assign mgmt_ext = cfg.management_port_target_select;
    // internal lines driven low while the port is the target.
    assign int_mdc_nxt = mgmt_ext ? 1'b0 : mac_mdc;
    assign int_mdio_o_nxt = mgmt_ext ? 1'b0 : mac_mdio_o;
    assign int_mdio_oe_nxt = mgmt_ext ? 1'b1 : mac_mdio_oe;
    // external data released and clock held low otherwise.
    assign ext_mdc_nxt = mgmt_ext ? mac_mdc : 1'b0;
    assign ext_mdio_o_nxt = mgmt_ext ? mac_mdio_o : 1'b0;
    assign ext_mdio_oe_nxt = mgmt_ext ? mac_mdio_oe : 1'b0;
    // returning data comes from the chosen target.
    assign mac_mdio_i_nxt = mgmt_ext ? ext_mdio_i : int_mdio_i;

endmodule

// ---- logic/mps_source_select.sv ----
// Hardware configuration register and MII source selection top level.
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/1ps
module mps_source_select (
    // Clock and reset.
    input wire logic CLOCK,
    input wire logic RESET_N,
    // Register port.
    input wire logic [mps_pkg::MPS_ADDR_W-1:0] REG_ADDR,
    input wire logic [mps_pkg::MPS_DATA_W-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [mps_pkg::MPS_DATA_W-1:0] REG_RDATA,
    // MAC side.
    input wire logic [mps_pkg::MPS_NIB_W-1:0] MAC_TXD,
    input wire logic MAC_TX_EN,
    input wire logic MAC_TX_ER,
    output logic [mps_pkg::MPS_NIB_W-1:0] MAC_RXD,
    output logic MAC_RX_DV,
    output logic MAC_RX_ER,
    output logic MAC_CRS,
    output logic MAC_COL,
    output logic MAC_RX_CLK,
    output logic MAC_TX_CLK,
    input wire logic MAC_MDC,
    input wire logic MAC_MDIO_O,
    input wire logic MAC_MDIO_OE,
    output logic MAC_MDIO_I,
    // Internal PHY side.
    output logic [mps_pkg::MPS_NIB_W-1:0] INT_TXD,
    output logic INT_TX_EN,
    output logic INT_TX_ER,
    input wire logic [mps_pkg::MPS_NIB_W-1:0] INT_RXD,
    input wire logic INT_RX_DV,
    input wire logic INT_RX_ER,
    input wire logic INT_CRS,
    input wire logic INT_COL,
    input wire logic INT_RX_CLK,
    input wire logic INT_TX_CLK,
    output logic INT_MDC,
    output logic INT_MDIO_O,
    output logic INT_MDIO_OE,
    input wire logic INT_MDIO_I,
    // External MII port side.
    output logic [mps_pkg::MPS_NIB_W-1:0] EXT_TXD,
    output logic EXT_TX_EN,
    output logic EXT_TX_ER,
    input wire logic [mps_pkg::MPS_NIB_W-1:0] EXT_RXD,
    input wire logic EXT_RX_DV,
    input wire logic EXT_RX_ER,
    input wire logic EXT_CRS,
    input wire logic EXT_COL,
    input wire logic EXT_RX_CLK,
    input wire logic EXT_TX_CLK,
    output logic EXT_MDC,
    output logic EXT_MDIO_O,
    output logic EXT_MDIO_OE,
    input wire logic EXT_MDIO_I
);
    import mps_pkg::*;

    // Register fields and strap state.
    logic [1:0] clk_sel_r;
    logic mgmt_sel_r;
    logic port_en_r;
    logic present_r;
    logic present_nxt;
    mps_strap_type strap_r;
    mps_strap_type strap_nxt;
    logic [MPS_DATA_W-1:0] rdata_r;

    // Routed values and their output registers.
    logic [MPS_RX_W-1:0] mac_rx_nxt;
    logic [MPS_RX_W-1:0] mac_rx_r;
    logic mac_rx_clk_nxt;
    logic mac_tx_clk_nxt;
    logic mac_mdio_i_nxt;
    logic [MPS_TX_W-1:0] int_tx_nxt;
    logic [MPS_TX_W-1:0] int_tx_r;
    logic [MPS_TX_W-1:0] ext_tx_nxt;
    logic [MPS_TX_W-1:0] ext_tx_r;
    logic int_mdc_nxt;
    logic int_mdio_o_nxt;
    logic int_mdio_oe_nxt;
    logic ext_mdc_nxt;
    logic ext_mdio_o_nxt;
    logic ext_mdio_oe_nxt;

    wire logic hit;
    wire logic wr_hit;
    wire logic rd_hit;
    wire logic [MPS_DATA_W-1:0] reg_view;
    wire logic [MPS_DATA_W-1:0] rdata_nxt;

    mps_route_if sel_if ();

    assign sel_if.mii_clock_source_select = clk_sel_r;
    assign sel_if.management_port_target_select = mgmt_sel_r;
    assign sel_if.outboard_mii_port_enable = port_en_r;

    // Address decode for the single mapped register.
    assign hit = (REG_ADDR == MPS_CONFIG_OFFSET);
    assign wr_hit = REG_WR && hit;
    assign rd_hit = REG_RD && hit;

    // bits above the used fields and unused low bits read zero.
    assign reg_view = {{(MPS_DATA_W-MPS_USED_MSB-1){1'b0}}, clk_sel_r, mgmt_sel_r,
                       present_r, port_en_r, 2'h0};
    // Unmapped reads and idle cycles return zero.
    assign rdata_nxt = rd_hit ? reg_view : '0;

    // writable fields load from a register write; reserved bits dropped.
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            clk_sel_r <= MPS_CLK_SEL_RST;
            mgmt_sel_r <= MPS_MGMT_SEL_RST;
            port_en_r <= MPS_PORT_EN_RST;
        end else if (wr_hit) begin
            clk_sel_r <= REG_WDATA[MPS_CLK_SEL_MSB:MPS_CLK_SEL_LSB];
            mgmt_sel_r <= REG_WDATA[MPS_MGMT_SEL_BIT];
            port_en_r <= REG_WDATA[MPS_PORT_EN_BIT];
        end
    end

    // the strap is caught on the first edge after reset release.
    always_comb begin
        strap_nxt = strap_r;
        present_nxt = present_r;
        case (strap_r)
            MPS_STRAP_WAIT: begin
                present_nxt = EXT_MDIO_I;
                strap_nxt = MPS_STRAP_HELD;
            end
            MPS_STRAP_HELD: begin
                strap_nxt = MPS_STRAP_HELD;
            end
            default: begin
                strap_nxt = MPS_STRAP_WAIT;
            end
        endcase
    end

    // the latched strap feeds only the read view.
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            strap_r <= MPS_STRAP_WAIT;
            present_r <= MPS_PRESENT_RST;
        end else begin
            strap_r <= strap_nxt;
            present_r <= present_nxt;
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    mps_route u_route (
        .cfg(sel_if.route),
        .mac_tx({MAC_TXD, MAC_TX_EN, MAC_TX_ER}),
        .mac_mdc(MAC_MDC),
        .mac_mdio_o(MAC_MDIO_O),
        .mac_mdio_oe(MAC_MDIO_OE),
        .mac_rx_nxt(mac_rx_nxt),
        .mac_rx_clk_nxt(mac_rx_clk_nxt),
        .mac_tx_clk_nxt(mac_tx_clk_nxt),
        .mac_mdio_i_nxt(mac_mdio_i_nxt),
        .int_rx({INT_RXD, INT_RX_DV, INT_RX_ER, INT_CRS, INT_COL}),
        .int_rx_clk(INT_RX_CLK),
        .int_tx_clk(INT_TX_CLK),
        .int_mdio_i(INT_MDIO_I),
        .int_tx_nxt(int_tx_nxt),
        .int_mdc_nxt(int_mdc_nxt),
        .int_mdio_o_nxt(int_mdio_o_nxt),
        .int_mdio_oe_nxt(int_mdio_oe_nxt),
        .ext_rx({EXT_RXD, EXT_RX_DV, EXT_RX_ER, EXT_CRS, EXT_COL}),
        .ext_rx_clk(EXT_RX_CLK),
        .ext_tx_clk(EXT_TX_CLK),
        .ext_mdio_i(EXT_MDIO_I),
        .ext_tx_nxt(ext_tx_nxt),
        .ext_mdc_nxt(ext_mdc_nxt),
        .ext_mdio_o_nxt(ext_mdio_o_nxt),
        .ext_mdio_oe_nxt(ext_mdio_oe_nxt)
    );

    // Every routed signal passes one output flip-flop; reset idles all lines.
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            mac_rx_r <= '0;
            MAC_RX_CLK <= 1'b0;
            MAC_TX_CLK <= 1'b0;
            MAC_MDIO_I <= 1'b0;
            int_tx_r <= '0;
            INT_MDC <= 1'b0;
            INT_MDIO_O <= 1'b0;
            INT_MDIO_OE <= 1'b0;
            ext_tx_r <= '0;
            EXT_MDC <= 1'b0;
            EXT_MDIO_O <= 1'b0;
            EXT_MDIO_OE <= 1'b0;
        end else begin
            mac_rx_r <= mac_rx_nxt;
            MAC_RX_CLK <= mac_rx_clk_nxt;
            MAC_TX_CLK <= mac_tx_clk_nxt;
            MAC_MDIO_I <= mac_mdio_i_nxt;
            int_tx_r <= int_tx_nxt;
            INT_MDC <= int_mdc_nxt;
            INT_MDIO_O <= int_mdio_o_nxt;
            INT_MDIO_OE <= int_mdio_oe_nxt;
            ext_tx_r <= ext_tx_nxt;
            EXT_MDC <= ext_mdc_nxt;
            EXT_MDIO_O <= ext_mdio_o_nxt;
            EXT_MDIO_OE <= ext_mdio_oe_nxt;
        end
    end

    assign REG_RDATA = rdata_r;
    assign {MAC_RXD, MAC_RX_DV, MAC_RX_ER, MAC_CRS, MAC_COL} = mac_rx_r;
    assign {INT_TXD, INT_TX_EN, INT_TX_ER} = int_tx_r;
    assign {EXT_TXD, EXT_TX_EN, EXT_TX_ER} = ext_tx_r;

    // Checks start on the second edge after release, once outputs have left their reset values.
    logic live_r;

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            live_r <= 1'b0;
        end else begin
            live_r <= 1'b1;
        end
    end

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RESET_N || !live_r);

    sequence strap_catch;
        (strap_r == MPS_STRAP_WAIT) ##1 (present_r == $past(EXT_MDIO_I));
    endsequence

    sequence strap_hold;
        (strap_r == MPS_STRAP_HELD) [*4];
    endsequence

    AST_CLK_SEL_WRITE: assert property (
        wr_hit |=> clk_sel_r == $past(REG_WDATA[MPS_CLK_SEL_MSB:MPS_CLK_SEL_LSB]))
        else $error("Clock source field did not load the written value.");

    AST_CLK_OFF: assert property (
        clk_sel_r == MPS_CLK_OFF |=> !MAC_RX_CLK && !MAC_TX_CLK)
        else $error("Disabled clock code let a clock through.");

    AST_CLK_EXT: assert property (
        clk_sel_r == MPS_CLK_EXT |=> MAC_RX_CLK == $past(EXT_RX_CLK)
            && MAC_TX_CLK == $past(EXT_TX_CLK))
        else $error("External clock code did not route port clocks.");

    AST_CLK_INDEP: assert property (
        (clk_sel_r == MPS_CLK_INT_B) && port_en_r |=> MAC_RX_CLK == $past(INT_RX_CLK))
        else $error("Port enable disturbed the clock routing.");

    AST_MGMT_INT: assert property (
        !mgmt_sel_r |=> MAC_MDIO_I == $past(INT_MDIO_I) && INT_MDC == $past(MAC_MDC))
        else $error("Management traffic missed the internal PHY.");

    AST_MGMT_EXT: assert property (
        mgmt_sel_r |=> EXT_MDC == $past(MAC_MDC)
            && MAC_MDIO_I == $past(EXT_MDIO_I))
        else $error("Management traffic missed the external port.");

    AST_INT_MGMT_LOW: assert property (
        mgmt_sel_r |=> !INT_MDC && !INT_MDIO_O && INT_MDIO_OE)
        else $error("Internal management lines not driven low.");

    AST_EXT_MGMT_IDLE: assert property (
        !mgmt_sel_r |=> !EXT_MDIO_OE && !EXT_MDC)
        else $error("External management pins not idle.");

    AST_PORT_EXT: assert property (
        port_en_r |=> ext_tx_r == $past({MAC_TXD, MAC_TX_EN, MAC_TX_ER}) && int_tx_r == '0)
        else $error("Enabled port did not carry MAC transmit data.");

    AST_PORT_INT: assert property (
        !port_en_r |=> ext_tx_r == '0 && mac_rx_r == $past({INT_RXD, INT_RX_DV,
            INT_RX_ER, INT_CRS, INT_COL}))
        else $error("Internal PHY not connected with port disabled.");

    AST_STRAP_CATCH: assert property (
        $rose(RESET_N) |-> strap_catch)
        else $error("Strap not sampled after reset release.");

    AST_STRAP_STABLE: assert property (
        strap_r == MPS_STRAP_HELD |=> $stable(present_r) ##0 strap_hold)
        else $error("Latched strap changed after capture.");

    AST_READ_VIEW: assert property (
        rd_hit |=> REG_RDATA[MPS_PRESENT_BIT] == $past(present_r)
            && REG_RDATA[MPS_DATA_W-1:MPS_USED_MSB+1] == '0)
        else $error("Read data disagrees with presence bit or reserved bits.");

    AST_READ_MISS: assert property (
        !rd_hit |=> REG_RDATA == '0)
        else $error("Read data present outside its read slot.");

endmodule

// ---- verification/mps_phy_model.sv ----
// Behavioural PHY model standing at the far side of the MII and management port.
`timescale 1ns/1ps
module mps_phy_model #(
    parameter int DIV = 1,
    parameter int SEED = 1
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Management line.
    input wire logic pull,
    input wire logic host_mdio_o,
    input wire logic host_mdio_oe,
    output wire logic mdio,
    // Receive bundle and free running clocks.
    output logic [7:0] rx,
    output logic rx_clk,
    output logic tx_clk
);
    int seed = SEED;
    int cnt;
    logic drv;
    logic dout;

    // A line released by both host and PHY falls back to its pull level, so a stale value never shows.
    assign mdio = host_mdio_oe ? host_mdio_o : (drv ? dout : pull);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx <= 8'h00;
            rx_clk <= 1'b0;
            tx_clk <= 1'b0;
            cnt <= 0;
            drv <= 1'b0;
            dout <= 1'b0;
        end else begin
            rx <= 8'($random(seed));
            cnt <= (cnt + 1) % DIV;
            if (cnt == 0) begin
                rx_clk <= ~rx_clk;
            end
            if (cnt == DIV - 1) begin
                tx_clk <= ~tx_clk;
            end
            // The PHY answers only while the host has let go of the line.
            drv <= ~host_mdio_oe & 1'($random(seed));
            dout <= 1'($random(seed));
        end
    end
endmodule

// ---- verification/mps_source_select_tb_top.sv ----
// Self-checking testbench for the PHY source selection block.
`timescale 1ns/1ps
module mps_source_select_tb_top;
    import mps_pkg::*;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic strap = 1'b1;
    logic present;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    wire logic [31:0] reg_rdata;
    logic [5:0] mac_tx = 6'h0;
    logic [2:0] mac_mg = 3'h0;
    wire logic [7:0] mac_rx;
    wire logic [7:0] int_rx;
    wire logic [7:0] ext_rx;
    wire logic [5:0] int_tx;
    wire logic [5:0] ext_tx;
    wire logic [2:0] int_mg;
    wire logic [2:0] ext_mg;
    wire logic [1:0] mac_ck;
    wire logic [1:0] int_ck;
    wire logic [1:0] ext_ck;
    wire logic mac_mdio_i;
    wire logic int_mdio_w;
    wire logic ext_mdio_w;
    logic [1:0] sh_clk = 2'h0;
    logic sh_tgt = 1'b0;
    logic sh_en = 1'b0;
    logic chk_en = 1'b0;
    logic [31:0] snap;
    int seed = 32'h7fa0860d;
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #10 clock = ~clock;

    mps_source_select dut_u (.CLOCK(clock), .RESET_N(reset_n), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .MAC_TXD(mac_tx[5:2]), .MAC_TX_EN(mac_tx[1]), .MAC_TX_ER(mac_tx[0]),
        .MAC_RXD(mac_rx[7:4]), .MAC_RX_DV(mac_rx[3]), .MAC_RX_ER(mac_rx[2]),
        .MAC_CRS(mac_rx[1]), .MAC_COL(mac_rx[0]), .MAC_RX_CLK(mac_ck[1]),
        .MAC_TX_CLK(mac_ck[0]), .MAC_MDC(mac_mg[2]), .MAC_MDIO_O(mac_mg[1]),
        .MAC_MDIO_OE(mac_mg[0]), .MAC_MDIO_I(mac_mdio_i),
        .INT_TXD(int_tx[5:2]), .INT_TX_EN(int_tx[1]), .INT_TX_ER(int_tx[0]),
        .INT_RXD(int_rx[7:4]), .INT_RX_DV(int_rx[3]), .INT_RX_ER(int_rx[2]),
        .INT_CRS(int_rx[1]), .INT_COL(int_rx[0]), .INT_RX_CLK(int_ck[1]),
        .INT_TX_CLK(int_ck[0]), .INT_MDC(int_mg[2]), .INT_MDIO_O(int_mg[1]),
        .INT_MDIO_OE(int_mg[0]), .INT_MDIO_I(int_mdio_w),
        .EXT_TXD(ext_tx[5:2]), .EXT_TX_EN(ext_tx[1]), .EXT_TX_ER(ext_tx[0]),
        .EXT_RXD(ext_rx[7:4]), .EXT_RX_DV(ext_rx[3]), .EXT_RX_ER(ext_rx[2]),
        .EXT_CRS(ext_rx[1]), .EXT_COL(ext_rx[0]), .EXT_RX_CLK(ext_ck[1]),
        .EXT_TX_CLK(ext_ck[0]), .EXT_MDC(ext_mg[2]), .EXT_MDIO_O(ext_mg[1]),
        .EXT_MDIO_OE(ext_mg[0]), .EXT_MDIO_I(ext_mdio_w));

    // Internal PHY answers promptly, the external one with slower clocks.
    mps_phy_model #(.DIV(1), .SEED(11)) int_phy (.clk(clock), .rst_n(reset_n), .pull(1'b1),
        .host_mdio_o(int_mg[1]), .host_mdio_oe(int_mg[0]), .mdio(int_mdio_w),
        .rx(int_rx), .rx_clk(int_ck[1]), .tx_clk(int_ck[0]));
    mps_phy_model #(.DIV(3), .SEED(23)) ext_phy (.clk(clock), .rst_n(reset_n), .pull(strap),
        .host_mdio_o(ext_mg[1]), .host_mdio_oe(ext_mg[0]), .mdio(ext_mdio_w),
        .rx(ext_rx), .rx_clk(ext_ck[1]), .tx_clk(ext_ck[0]));

    function automatic logic [31:0] route_exp(logic [1:0] c, logic t, logic e, logic [31:0] s);
        logic [1:0] ck;
        ck = (c == MPS_CLK_EXT) ? s[12:11] : ((c == MPS_CLK_OFF) ? 2'b00 : s[14:13]);
        return {3'h0, e ? s[22:15] : s[30:23], ck, e ? 6'h0 : s[10:5], e ? s[10:5] : 6'h0,
            t ? 3'b001 : s[4:2], t ? s[4:2] : 3'b000, t ? s[0] : s[1]};
    endfunction

    task automatic check(string name, logic [31:0] exp, logic [31:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(logic [7:0] a, output logic [31:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic do_reset(logic lvl);
        logic [31:0] v;
        reset_n <= 1'b0;
        strap <= lvl;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        present = lvl;
        {sh_clk, sh_tgt, sh_en} = 4'h0;
        rd(MPS_CONFIG_OFFSET, v);
        // The strap level flips after capture; the latched bit must not follow.
        strap <= ~lvl;
        check("reset value", {28'h0, lvl, 3'h0}, v);
        $display("test reset strap %0d done", lvl);
    endtask

    task automatic sweep;
        logic [31:0] d;
        logic [31:0] v;
        logic [7:0] a;
        for (int k = 0; k < 32; k++) begin
            d = $random(seed);
            d[6:2] = 5'(k);
            chk_en = 1'b0;
            // MAC traffic halted before the register write.
            mac_tx <= 6'h0;
            wr(MPS_CONFIG_OFFSET, d);
            rd(MPS_CONFIG_OFFSET, v);
            check("hardware_configuration", (d & 32'h74) | {28'h0, present, 3'h0}, v);
            a = 8'($random(seed));
            if (a == MPS_CONFIG_OFFSET) begin
                a = 8'h00;
            end
            wr(a, 32'hffffffff);
            rd(a, v);
            check("unmapped", 32'h0, v);
            {sh_clk, sh_tgt, sh_en} = {d[6:5], d[4], d[2]};
            repeat (3) @(posedge clock);
            chk_en = 1'b1;
            repeat (12) begin
                @(posedge clock);
                mac_tx <= 6'($random(seed));
                mac_mg <= 3'($random(seed));
            end
        end
        chk_en = 1'b0;
        $display("test sweep strap %0d done", present);
    endtask

    // Inputs as the design sampled them at this edge, before any new drive lands.
    always @(posedge clock) begin
        snap = {1'b0, int_rx, ext_rx, int_ck, ext_ck, mac_tx, mac_mg, int_mdio_w, ext_mdio_w};
    end

    always @(negedge clock) begin
        if (chk_en) begin
            check("routing", route_exp(sh_clk, sh_tgt, sh_en, snap), {3'h0, mac_rx, mac_ck,
                int_tx, ext_tx, int_mg, ext_mg, mac_mdio_i});
        end
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            conclude();
        end
    end

    initial begin
        do_reset(1'b1);
        sweep();
        do_reset(1'b0);
        sweep();
        conclude();
    end
endmodule
